// ---- dv/psp_link_checker.sv ----
// Assertion checker for the compressed-data link between source and parser device
`timescale 1ns/1ps
module psp_link_checker (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Link signals
	input wire logic [7:0] data,
	input wire logic audio_data_strobe,
	input wire logic video_data_strobe,
	input wire logic aud_req,
	input wire logic vid_req,
	// Side controls that shape the link
	input wire logic single_strobe_in,
	input wire logic aud_es_ready_in,
	input wire logic vid_es_ready_in
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Single-strobe setting held across two edges, so no byte launched before it is in flight
	sequence ss_steady;
		single_strobe_in ##1 single_strobe_in;
	endsequence
	// Shared bus carries one stream at a time
	strobe_excl_a: assert property (!(audio_data_strobe && video_data_strobe))
		else $error("audio and video strobes high together");
	// Source only strobes a stream whose request was up
	aud_req_gate_a: assert property (audio_data_strobe |-> $past(aud_req))
		else $error("audio byte sent without request");
	vid_req_gate_a: assert property (video_data_strobe |-> $past(vid_req))
		else $error("video byte sent without request");
	// Data bus only moves together with a strobe
	data_hold_a: assert property (!audio_data_strobe && !video_data_strobe |-> $stable(data))
		else $error("data bus changed without strobe");
	// Single-strobe modes leave the audio strobe unused
	single_strobe_a: assert property (ss_steady |-> !audio_data_strobe)
		else $error("audio strobe used in single strobe mode");
	// A stalled elementary output withdraws its request one edge later
	aud_stall_a: assert property (!aud_es_ready_in |=> !aud_req)
		else $error("audio request kept while output stalled");
	vid_stall_a: assert property (!vid_es_ready_in |=> !vid_req)
		else $error("video request kept while output stalled");
endmodule // psp_link_checker

// ---- dv/testbench.sv ----
// Self-checking bench for the stream source and parser device pair
`timescale 1ns/1ps
module testbench;
	import psp_pkg::*;
	// Stimulus
	logic clk_in = 1'b0, rst_in = 1'b1;
	logic [7:0] tx_data_in = 8'h00;
	logic tx_audio_in = 1'b0, tx_valid_in = 1'b0, single_strobe_in = 1'b0;
	logic aud_es_ready_in = 1'b1, vid_es_ready_in = 1'b1, aud_pic_in = 1'b0, vid_pic_in = 1'b0;
	logic [7:0] s_awaddr_in = 8'h00, s_araddr_in = 8'h00;
	logic [31:0] s_wdata_in = 32'h0;
	logic [3:0] s_wstrb_in = 4'hF;
	logic s_awvalid_in = 1'b0, s_wvalid_in = 1'b0, s_bready_in = 1'b0, s_arvalid_in = 1'b0, s_rready_in = 1'b0;
	// Observed
	logic tx_ready_out, aud_es_valid_out, vid_es_valid_out, irq_out;
	logic [7:0] aud_es_data_out, vid_es_data_out;
	logic s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
	logic [1:0] s_bresp_out, s_rresp_out;
	logic [31:0] s_rdata_out;
	// Model: expected elementary bytes per stream
	logic [7:0] qa[$], qv[$];
	int n_fail = 0, checks_done = 0;
	psp_link_if lk();
	psp_host u_psp_host (.clk_in, .rst_in, .tx_data_in, .tx_audio_in, .tx_valid_in, .tx_ready_out,
		.single_strobe_in, .lk(lk.host));
	psp_device u_psp_device (.clk_in, .rst_in, .lk(lk.dev), .aud_es_data_out, .aud_es_valid_out,
		.aud_es_ready_in, .vid_es_data_out, .vid_es_valid_out, .vid_es_ready_in, .aud_pic_in, .vid_pic_in,
		.irq_out, .s_awaddr_in, .s_awvalid_in, .s_awready_out, .s_wdata_in, .s_wstrb_in, .s_wvalid_in,
		.s_wready_out, .s_bresp_out, .s_bvalid_out, .s_bready_in, .s_araddr_in, .s_arvalid_in,
		.s_arready_out, .s_rdata_out, .s_rresp_out, .s_rvalid_out, .s_rready_in);
	psp_link_checker u_psp_link_checker (.clk_in, .rst_in, .data(lk.data),
		.audio_data_strobe(lk.audio_data_strobe), .video_data_strobe(lk.video_data_strobe),
		.aud_req(lk.aud_req), .vid_req(lk.vid_req), .single_strobe_in, .aud_es_ready_in, .vid_es_ready_in);
	// 20 MHz clock
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	task automatic summarize();
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic tmo();
		n_fail++;
		summarize();
	endtask
	// Output consumers stall now and then, so requests must drop and recover
	always @(posedge clk_in) begin
		aud_es_ready_in <= ($urandom % 4) != 0;
		vid_es_ready_in <= ($urandom % 4) != 0;
	end
	// Compare every elementary byte with the model queues, in order
	always @(posedge clk_in) begin
		if (!rst_in && aud_es_valid_out) chk("aud_es", aud_es_data_out, qa.size() ? qa.pop_front() : 9'h100);
		if (!rst_in && vid_es_valid_out) chk("vid_es", vid_es_data_out, qv.size() ? qv.pop_front() : 9'h100);
	end
	// AXI4-Lite write, each channel released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge clk_in);
		s_awaddr_in <= a;
		s_awvalid_in <= 1'b1;
		s_wdata_in <= d;
		s_wvalid_in <= 1'b1;
		s_bready_in <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_in);
			if (s_awvalid_in && s_awready_out) s_awvalid_in <= 1'b0;
			if (s_wvalid_in && s_wready_out) s_wvalid_in <= 1'b0;
			if (s_bvalid_out === 1'b1) break;
		end
		if (i == 50) tmo();
		s_bready_in <= 1'b0;
		chk("bresp", s_bresp_out, er);
	endtask
	// AXI4-Lite read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge clk_in);
		s_araddr_in <= a;
		s_arvalid_in <= 1'b1;
		s_rready_in <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_in);
			if (s_arvalid_in && s_arready_out) s_arvalid_in <= 1'b0;
			if (s_rvalid_out === 1'b1) break;
		end
		if (i == 50) tmo();
		s_rready_in <= 1'b0;
		d = s_rdata_out;
		chk("rresp", s_rresp_out, er);
	endtask
	// One byte through the source, held until taken
	task automatic send(input logic [7:0] b, input logic aud);
		int i;
		@(posedge clk_in);
		tx_data_in <= b;
		tx_audio_in <= aud;
		tx_valid_in <= 1'b1;
		for (i = 0; i < 500; i++) begin
			@(posedge clk_in);
			if (tx_ready_out === 1'b1) break;
		end
		if (i == 500) tmo();
		tx_valid_in <= 1'b0;
	endtask
	// PES or MPEG-1 packet with a stamp; payload expected only for the programmed IDs
	task automatic pkt(input logic [7:0] id, input logic aud, input int n, input logic [32:0] ts, input logic m1);
		logic [7:0] b[$];
		int k;
		int h;
		b = '{8'h00, 8'h00, 8'h01, id, 8'h00, 8'(n + 8), 8'h80, 8'h80, 8'h05, {4'h2, ts[32:30], 1'b1},
			ts[29:22], {ts[21:15], 1'b1}, ts[14:7], {ts[6:0], 1'b1}};
		// MPEG-1 header form has no flag and header length bytes
		if (m1) begin
			repeat (3) b.delete(6);
			b[5] = 8'(n + 5);
		end
		h = m1 ? 11 : 14;
		for (k = 0; k < n; k++) b.push_back(8'($urandom));
		for (k = 0; k < b.size(); k++) begin
			if (k >= h && id == 8'hC0) qa.push_back(b[k]);
			if (k >= h && id == 8'hE0) qv.push_back(b[k]);
			send(b[k], aud);
		end
	endtask
	task automatic drain();
		int i;
		for (i = 0; i < 300 && (qa.size() || qv.size()); i++) @(posedge clk_in);
		if (i == 300) tmo();
	endtask
	initial begin
		logic [31:0] d;
		logic [32:0] ts;
		logic [7:0] b;
		psp_mode_t md;
		// automatic mode only sees PES-style packets here
		psp_mode_t modes[4] = '{MODE_AUTO, MODE_PES, MODE_PROG, MODE_SYS1};
		int k;
		void'($urandom(32'h0b162851));
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		// Registers clear after reset; one unmapped offset answers with an error
		for (k = 0; k < 9; k++) begin
			rd(8'(k * 4), d, k < 8 ? RESP_OK : RESP_ERR);
			chk("reg_rst", d, 32'h0);
		end
		wr(OFS_DET, 32'h2, RESP_ERR);
		wr(OFS_AUD_CFG, 32'h0000_C000, RESP_OK);
		// Parsers disabled: both strobes carry plain elementary bytes
		for (k = 0; k < 16; k++) begin
			b = 8'($urandom);
			if (k % 2) qa.push_back(b);
			else qv.push_back(b);
			send(b, k % 2);
		end
		drain();
		// Each parse mode: filtering, routing by strobe and stamp delivery
		for (k = 0; k < 4; k++) begin
			md = modes[k];
			@(posedge clk_in);
			single_strobe_in <= (md == MODE_PROG || md == MODE_SYS1);
			wr(OFS_VID_CFG, {16'h0, 8'hE0, md, 5'h0, 1'b1}, RESP_OK);
			wr(OFS_AUD_SEL, md == MODE_AUTO ? 32'h5 : (md == MODE_SYS1 ? 32'h1 : 32'h4), RESP_OK);
			ts = {1'(k), 32'($urandom)};
			// source keeps audio and video packets apart
			pkt(8'hE0, 1'b0, 6 + k, ts, md == MODE_SYS1);
			pkt(8'hE1, 1'b0, 4, ~ts, md == MODE_SYS1);
			pkt(8'hC0, 1'b1, 5, ts, md == MODE_SYS1);
			pkt(8'hC1, 1'b1, 3, ts, md == MODE_SYS1);
			drain();
			@(posedge clk_in);
			vid_pic_in <= 1'b1;
			aud_pic_in <= 1'b1;
			@(posedge clk_in);
			vid_pic_in <= 1'b0;
			aud_pic_in <= 1'b0;
			repeat (3) @(posedge clk_in);
			rd(OFS_INT_ST, d, RESP_OK);
			chk("vts_flag", d[IRQ_VTS], 1'b1);
			chk("ats_flag", d[IRQ_ATS], 1'b1);
			chk("irq_masked", irq_out, 1'b0);
			wr(OFS_INT_MSK, 32'h2, RESP_OK);
			repeat (2) @(posedge clk_in);
			chk("irq_set", irq_out, 1'b1);
			rd(OFS_VID_TS, d, RESP_OK);
			chk("vid_stamp", d, ts[31:0]);
			rd(OFS_AUD_TS, d, RESP_OK);
			chk("aud_stamp", d, ts[31:0]);
			rd(OFS_DET, d, RESP_OK);
			chk("vid_stamp32", d[DET_VTS32_BIT], ts[32]);
			chk("aud_stamp32", d[DET_ATS32_BIT], ts[32]);
			if (md == MODE_AUTO) chk("det_mode", d[DET_BIT], 1'b1);
			wr(OFS_INT_ST, 32'hF, RESP_OK);
			repeat (2) @(posedge clk_in);
			chk("irq_clr", irq_out, 1'b0);
			wr(OFS_INT_MSK, 32'h0, RESP_OK);
		end
		summarize();
	end
endmodule // testbench

// ---- hdl/psp_device.sv ----
// Parser device: link input, two parsers, AXI4-Lite registers, interrupt
`timescale 1ns/1ps
module psp_device
	import psp_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Compressed-data link
	psp_link_if.dev lk,
	// Elementary stream outputs
	output logic [7:0] aud_es_data_out,
	output logic aud_es_valid_out,
	input wire logic aud_es_ready_in,
	output logic [7:0] vid_es_data_out,
	output logic vid_es_valid_out,
	input wire logic vid_es_ready_in,
	// Picture decode starts
	input wire logic aud_pic_in,
	input wire logic vid_pic_in,
	// Interrupt
	output logic irq_out,
	// AXI4-Lite write
	input wire logic [7:0] s_awaddr_in,
	input wire logic s_awvalid_in,
	output logic s_awready_out,
	input wire logic [31:0] s_wdata_in,
	input wire logic [3:0] s_wstrb_in,
	input wire logic s_wvalid_in,
	output logic s_wready_out,
	output logic [1:0] s_bresp_out,
	output logic s_bvalid_out,
	input wire logic s_bready_in,
	// AXI4-Lite read
	input wire logic [7:0] s_araddr_in,
	input wire logic s_arvalid_in,
	output logic s_arready_out,
	output logic [31:0] s_rdata_out,
	output logic [1:0] s_rresp_out,
	output logic s_rvalid_out,
	input wire logic s_rready_in
);
	logic [31:0] acfg_r, acfg_nxt; // audio_stream_cfg
	logic [31:0] vcfg_r, vcfg_nxt; // video_stream_cfg
	logic [2:0] ais_r, ais_nxt; // audio_input_select
	logic [IRQ_W-1:0] st_r, st_nxt, msk_r, msk_nxt;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic bv_r, bv_nxt, rv_r, rv_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic areq_r, vreq_r, irq_r;
	logic do_wr;
	logic [31:0] wmerge;
	logic [IRQ_W-1:0] ev;
	psp_mode_t mode, eff_mode;
	logic ss, a_en, single, a_stb;
	logic single_r; // Strobe routing of the previous cycle
	logic a_run; // Low for one cycle after a routing switch
	logic a_mp2, v_mp2, a_tse, v_tse, a_ovf, v_ovf;
	logic [32:0] a_ts, v_ts;

	// Mode and strobe routing
	assign mode = psp_mode_t'(vcfg_r[CFG_MODE_LSB +: 2]);
	assign ss = vcfg_r[CFG_SS_BIT];
	assign a_en = (ais_r != 3'h0);
	assign eff_mode = (mode == MODE_AUTO) ? (v_mp2 ? MODE_PES : MODE_SYS1) : mode;
	assign single = ss && (eff_mode == MODE_SYS1 || eff_mode == MODE_PROG);
	assign a_stb = single ? (lk.video_data_strobe & a_en) : lk.audio_data_strobe;
	// A routing switch parks the audio parser for one cycle, so a packet it was
	// skipping on the video strobe cannot swallow the next audio packet
	assign a_run = (single == single_r);

	psp_parser u_aud (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.en_in(a_en && a_run),
		.sid_in(acfg_r[CFG_ID_LSB +: 8]),
		.dts_sel_in(acfg_r[CFG_SDT_BIT]),
		.byte_in(lk.data),
		.stb_in(a_stb && a_run),
		.pic_in(aud_pic_in),
		.es_data_out(aud_es_data_out),
		.es_valid_out(aud_es_valid_out),
		.mpeg2_out(a_mp2),
		.ts_out(a_ts),
		.ts_evt_out(a_tse),
		.ovf_out(a_ovf)
	);

	psp_parser u_vid (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.en_in(ss),
		.sid_in(vcfg_r[CFG_ID_LSB +: 8]),
		.dts_sel_in(acfg_r[CFG_SDT_BIT]),
		.byte_in(lk.data),
		.stb_in(lk.video_data_strobe),
		.pic_in(vid_pic_in),
		.es_data_out(vid_es_data_out),
		.es_valid_out(vid_es_valid_out),
		.mpeg2_out(v_mp2),
		.ts_out(v_ts),
		.ts_evt_out(v_tse),
		.ovf_out(v_ovf)
	);

	// Interrupt events from both parsers
	always_comb begin
		ev = '0;
		ev[IRQ_ATS] = a_tse;
		ev[IRQ_VTS] = v_tse;
		ev[IRQ_AOVF] = a_ovf;
		ev[IRQ_VOVF] = v_ovf;
	end

	// Byte-lane merge of the write data into the addressed register
	always_comb begin
		wmerge = 32'h0;
		if (awa_r == OFS_AUD_CFG) wmerge = acfg_r;
		else if (awa_r == OFS_VID_CFG) wmerge = vcfg_r;
		else if (awa_r == OFS_AUD_SEL) wmerge = {29'h0, ais_r};
		else if (awa_r == OFS_INT_MSK) wmerge = {28'h0, msk_r};
		for (int i = 0; i < 4; i++) begin
			if (ws_r[i]) wmerge[i*8 +: 8] = wd_r[i*8 +: 8];
		end
	end

	// Bus handshake and register next values
	always_comb begin
		aw_got_nxt = aw_got_r; w_got_nxt = w_got_r; awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r;
		bv_nxt = bv_r; br_nxt = br_r; rv_nxt = rv_r; rr_nxt = rr_r; rd_nxt = rd_r;
		acfg_nxt = acfg_r; vcfg_nxt = vcfg_r; ais_nxt = ais_r; msk_nxt = msk_r;
		// Address and data are taken in either order
		if (s_awvalid_in && s_awready_out) begin
			aw_got_nxt = 1'b1; awa_nxt = {s_awaddr_in[7:2], 2'b00};
		end
		if (s_wvalid_in && s_wready_out) begin
			w_got_nxt = 1'b1; wd_nxt = s_wdata_in; ws_nxt = s_wstrb_in;
		end
		do_wr = aw_got_r && w_got_r && !bv_r;
		if (do_wr) begin
			aw_got_nxt = 1'b0; w_got_nxt = 1'b0; bv_nxt = 1'b1; br_nxt = RESP_OK;
			if (awa_r == OFS_AUD_CFG) acfg_nxt = wmerge;
			else if (awa_r == OFS_VID_CFG) vcfg_nxt = wmerge;
			else if (awa_r == OFS_AUD_SEL) ais_nxt = wmerge[2:0];
			else if (awa_r == OFS_INT_MSK) msk_nxt = wmerge[IRQ_W-1:0];
			else if (awa_r == OFS_INT_ST) br_nxt = RESP_OK;
			else br_nxt = RESP_ERR;
		end
		if (bv_r && s_bready_in) bv_nxt = 1'b0;
		if (rv_r && s_rready_in) rv_nxt = 1'b0;
		// Read answer one cycle after the address is taken
		if (s_arvalid_in && s_arready_out) begin
			rv_nxt = 1'b1; rr_nxt = RESP_OK; rd_nxt = 32'h0;
			if (s_araddr_in[7:2] == OFS_AUD_CFG[7:2]) rd_nxt = acfg_r;
			else if (s_araddr_in[7:2] == OFS_VID_CFG[7:2]) rd_nxt = vcfg_r;
			else if (s_araddr_in[7:2] == OFS_AUD_SEL[7:2]) rd_nxt = {29'h0, ais_r};
			else if (s_araddr_in[7:2] == OFS_DET[7:2]) begin
				rd_nxt[DET_BIT] = v_mp2;
				rd_nxt[DET_ATS32_BIT] = a_ts[32];
				rd_nxt[DET_VTS32_BIT] = v_ts[32];
			end
			else if (s_araddr_in[7:2] == OFS_INT_ST[7:2]) rd_nxt = {28'h0, st_r};
			else if (s_araddr_in[7:2] == OFS_INT_MSK[7:2]) rd_nxt = {28'h0, msk_r};
			else if (s_araddr_in[7:2] == OFS_AUD_TS[7:2]) rd_nxt = a_ts[31:0];
			else if (s_araddr_in[7:2] == OFS_VID_TS[7:2]) rd_nxt = v_ts[31:0];
			else rr_nxt = RESP_ERR;
		end
		st_nxt = st_r;
		if (do_wr && awa_r == OFS_INT_ST) st_nxt = st_r & ~wmerge[IRQ_W-1:0];
		st_nxt = st_nxt | ev;
	end

	// Register state
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_got_r <= 1'b0; w_got_r <= 1'b0; awa_r <= 8'h00; wd_r <= 32'h0; ws_r <= 4'h0;
			bv_r <= 1'b0; br_r <= RESP_OK; rv_r <= 1'b0; rr_r <= RESP_OK; rd_r <= 32'h0;
			acfg_r <= RST_CFG; vcfg_r <= RST_CFG; ais_r <= 3'h0; msk_r <= RST_MSK; st_r <= '0;
		end else begin
			aw_got_r <= aw_got_nxt; w_got_r <= w_got_nxt; awa_r <= awa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
			bv_r <= bv_nxt; br_r <= br_nxt; rv_r <= rv_nxt; rr_r <= rr_nxt; rd_r <= rd_nxt;
			acfg_r <= acfg_nxt; vcfg_r <= vcfg_nxt; ais_r <= ais_nxt; msk_r <= msk_nxt; st_r <= st_nxt;
		end
	end

	// Ready flags, requests and interrupt, all registered
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_awready_out <= 1'b0; s_wready_out <= 1'b0; s_arready_out <= 1'b0;
			areq_r <= 1'b0; vreq_r <= 1'b0; irq_r <= 1'b0;
			single_r <= 1'b0;
		end else begin
			s_awready_out <= !aw_got_nxt && !bv_nxt && !(s_awvalid_in && s_awready_out);
			s_wready_out <= !w_got_nxt && !bv_nxt && !(s_wvalid_in && s_wready_out);
			s_arready_out <= !rv_nxt && !(s_arvalid_in && s_arready_out);
			// request follows sink room; one byte per cycle is enough
			// audio request idle in single mode
			areq_r <= aud_es_ready_in && !single;
			vreq_r <= vid_es_ready_in && (!single || aud_es_ready_in);
			irq_r <= |(st_nxt & msk_r);
			single_r <= single;
		end
	end

	assign s_bvalid_out = bv_r;
	assign s_bresp_out = br_r;
	assign s_rvalid_out = rv_r;
	assign s_rresp_out = rr_r;
	assign s_rdata_out = rd_r;
	assign lk.aud_req = areq_r;
	assign lk.vid_req = vreq_r;
	assign irq_out = irq_r;
endmodule // psp_device

// ---- hdl/psp_host.sv ----
// Stream source end: puts bytes on the shared bus with per-stream strobes
`timescale 1ns/1ps
module psp_host
	import psp_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// User byte source
	input wire logic [7:0] tx_data_in,
	input wire logic tx_audio_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	input wire logic single_strobe_in,
	// Compressed-data link
	psp_link_if.host lk
);
	logic [7:0] d_r, d_nxt;
	logic [7:0] bus_r, bus_nxt; // Byte shown on the shared bus, moves only with a strobe
	logic aud_r, aud_nxt, full_r, full_nxt, rdy_nxt;
	logic as_r, as_nxt, vs_r, vs_nxt;
	logic [7:0] gap_r, gap_nxt; // Cycles until next strobe allowed
	logic go;

	// Next values: one held byte, sent when its request is up
	always_comb begin
		d_nxt = d_r; aud_nxt = aud_r; full_nxt = full_r; gap_nxt = gap_r;
		as_nxt = 1'b0; vs_nxt = 1'b0;
		bus_nxt = bus_r;
		if (gap_r != 8'h0) gap_nxt = gap_r - 8'h1;
		go = full_r && (gap_r == 8'h0) && ((aud_r && !single_strobe_in) ? lk.aud_req : lk.vid_req);
		if (go) begin
			as_nxt = aud_r && !single_strobe_in;
			vs_nxt = !(aud_r && !single_strobe_in);
			full_nxt = 1'b0;
			bus_nxt = d_r;
			gap_nxt = 8'(BYTE_GAP_CYC - 1);
		end
		if (tx_valid_in && tx_ready_out) begin
			d_nxt = tx_data_in; aud_nxt = tx_audio_in; full_nxt = 1'b1;
		end
		rdy_nxt = !full_nxt;
	end

	// Registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			d_r <= 8'h00; aud_r <= 1'b0; full_r <= 1'b0; gap_r <= 8'h00;
			as_r <= 1'b0; vs_r <= 1'b0; tx_ready_out <= 1'b0;
			bus_r <= 8'h00;
		end else begin
			d_r <= d_nxt; aud_r <= aud_nxt; full_r <= full_nxt; gap_r <= gap_nxt;
			bus_r <= bus_nxt;
			as_r <= as_nxt; vs_r <= vs_nxt; tx_ready_out <= rdy_nxt;
		end
	end

	// Bus byte changes only at the edge that raises its strobe, then holds
	assign lk.data = bus_r;
	assign lk.audio_data_strobe = as_r;
	assign lk.video_data_strobe = vs_r;
endmodule // psp_host

// ---- hdl/psp_link_if.sv ----
// Compressed-data link between the stream source and the parser device
`timescale 1ns/1ps
interface psp_link_if;
	logic [7:0] data; // Shared data bus
	logic audio_data_strobe; // One-cycle byte strobe, audio
	logic video_data_strobe; // One-cycle byte strobe, video
	logic aud_req; // Device can take audio bytes
	logic vid_req; // Device can take video bytes
	modport dev (input data, input audio_data_strobe, input video_data_strobe, output aud_req, output vid_req);
	modport host (output data, output audio_data_strobe, output video_data_strobe, input aud_req, input vid_req);
endinterface

// ---- hdl/psp_parser.sv ----
// One packet parser with stream ID filter and stamp queue
`timescale 1ns/1ps
module psp_parser
	import psp_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Configuration
	input wire logic en_in,
	input wire logic [7:0] sid_in,
	input wire logic dts_sel_in,
	// Byte stream in
	input wire logic [7:0] byte_in,
	input wire logic stb_in,
	// Picture decode start
	input wire logic pic_in,
	// Elementary stream out
	output logic [7:0] es_data_out,
	output logic es_valid_out,
	// Status
	output logic mpeg2_out,
	output logic [32:0] ts_out,
	output logic ts_evt_out,
	output logic ovf_out
);
	typedef enum {S_HUNT, S_SID, S_LENH, S_LENL, S_H1, S_M1B, S_FLG, S_HLEN, S_HDR, S_PAY, S_SKIP} psp_st_t;
	psp_st_t st_r, st_nxt;
	logic [1:0] zc_r, zc_nxt; // Zero bytes seen
	logic [15:0] len_r, len_nxt; // Bytes left in packet
	logic [7:0] rem_r, rem_nxt; // Header bytes left
	logic [3:0] hidx_r, hidx_nxt; // Stamp field byte index
	logic keep_r, keep_nxt, hts_r, hts_nxt, dtsp_r, dtsp_nxt, push_r, push_nxt;
	logic det_r, det_nxt;
	logic [39:0] sh_r, sh_nxt; // Stamp byte shift
	logic [7:0] esd_nxt;
	logic esv_nxt, cap;
	logic [32:0] mem_r [0:(1<<TS_AW)-1]; // Stamp queue
	logic [TS_AW:0] wp_r, rp_r;
	logic full, empty;

	assign full = (wp_r[TS_AW] != rp_r[TS_AW]) && (wp_r[TS_AW-1:0] == rp_r[TS_AW-1:0]);
	assign empty = (wp_r == rp_r);

	// Byte parser next state
	always_comb begin
		st_nxt = st_r; zc_nxt = zc_r; len_nxt = len_r; rem_nxt = rem_r; hidx_nxt = hidx_r;
		keep_nxt = keep_r; hts_nxt = hts_r; dtsp_nxt = dtsp_r; det_nxt = det_r; sh_nxt = sh_r;
		push_nxt = 1'b0; esd_nxt = byte_in; esv_nxt = 1'b0; cap = 1'b0;
		if (!en_in) begin
			st_nxt = S_HUNT; zc_nxt = 2'h0; det_nxt = 1'b0; esv_nxt = stb_in;
		end else if (stb_in) begin
			if (st_r > S_LENL) len_nxt = len_r - 16'h1;
			case (st_r)
				S_HUNT: begin
					if (byte_in == 8'h00) zc_nxt = (zc_r == 2'h2) ? 2'h2 : zc_r + 2'h1;
					else begin
						zc_nxt = 2'h0;
						if (byte_in == SC_LAST && zc_r == 2'h2) st_nxt = S_SID;
					end
				end
				S_SID: begin
					keep_nxt = (byte_in == sid_in);
					st_nxt = (byte_in >= SID_LEN_MIN) ? S_LENH : S_HUNT;
				end
				S_LENH: begin
					len_nxt = {byte_in, 8'h00}; st_nxt = S_LENL;
				end
				S_LENL: begin
					len_nxt = {len_r[15:8], byte_in};
					st_nxt = ({len_r[15:8], byte_in} == 16'h0) ? S_HUNT : (keep_r ? S_H1 : S_SKIP);
					hts_nxt = 1'b0; dtsp_nxt = 1'b0; hidx_nxt = 4'h0;
				end
				S_H1, S_M1B: begin
					if (st_r == S_H1 && byte_in[7:6] == 2'b10) begin
						det_nxt = 1'b1; st_nxt = S_FLG;
					end else if (st_r == S_M1B) st_nxt = S_H1;
					else if (byte_in == STUFF) st_nxt = S_H1;
					else if (byte_in[7:6] == 2'b01) st_nxt = S_M1B;
					else if (byte_in[7:5] == 3'b001) begin
						hts_nxt = 1'b1; dtsp_nxt = byte_in[4]; hidx_nxt = 4'h1;
						rem_nxt = byte_in[4] ? 8'h09 : 8'h04; st_nxt = S_HDR;
						cap = !(dts_sel_in && byte_in[4]);
					end else st_nxt = S_PAY;
				end
				S_FLG: begin
					hts_nxt = byte_in[7]; dtsp_nxt = byte_in[7] & byte_in[6]; st_nxt = S_HLEN;
				end
				S_HLEN: begin
					rem_nxt = byte_in; st_nxt = (byte_in == 8'h0) ? S_PAY : S_HDR;
				end
				S_HDR: begin
					cap = (dts_sel_in && dtsp_r) ? (hidx_r >= 4'h5 && hidx_r <= 4'h9) : (hidx_r < 4'h5);
					hidx_nxt = hidx_r + 4'h1; rem_nxt = rem_r - 8'h1;
					if (rem_r == 8'h1) begin
						st_nxt = S_PAY; push_nxt = hts_r;
					end
				end
				S_PAY: esv_nxt = 1'b1;
				default: st_nxt = st_r;
			endcase
			if (cap) sh_nxt = {sh_r[31:0], byte_in};
			// End of packet returns to hunting
			if (st_r > S_LENL && len_r == 16'h1) begin
				st_nxt = S_HUNT; zc_nxt = 2'h0;
			end
		end
	end

	// Parser registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= S_HUNT; zc_r <= 2'h0; len_r <= 16'h0; rem_r <= 8'h0; hidx_r <= 4'h0;
			keep_r <= 1'b0; hts_r <= 1'b0; dtsp_r <= 1'b0; det_r <= 1'b0; push_r <= 1'b0;
			sh_r <= 40'h0; es_data_out <= 8'h00; es_valid_out <= 1'b0; mpeg2_out <= 1'b0;
		end else begin
			st_r <= st_nxt; zc_r <= zc_nxt; len_r <= len_nxt; rem_r <= rem_nxt; hidx_r <= hidx_nxt;
			keep_r <= keep_nxt; hts_r <= hts_nxt; dtsp_r <= dtsp_nxt; det_r <= det_nxt; push_r <= push_nxt;
			sh_r <= sh_nxt; es_data_out <= esd_nxt; es_valid_out <= esv_nxt; mpeg2_out <= det_nxt;
		end
	end

	// Stamp queue; a full queue drops the new stamp and flags it
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_r <= '0; rp_r <= '0; ts_out <= 33'h0; ts_evt_out <= 1'b0; ovf_out <= 1'b0;
		end else begin
			ovf_out <= push_r & full;
			if (push_r && !full) begin
				mem_r[wp_r[TS_AW-1:0]] <= {sh_r[35:33], sh_r[31:24], sh_r[23:17], sh_r[15:8], sh_r[7:1]};
				wp_r <= wp_r + 1'b1;
			end
			ts_evt_out <= pic_in & !empty;
			if (pic_in && !empty) begin
				ts_out <= mem_r[rp_r[TS_AW-1:0]];
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule // psp_parser

// ---- hdl/psp_pkg.sv ----
// Package with constants and types of the stream parser pair
// Functional notes
// - Take input bursts up to 100 Mbit/s losslessly
// - Accept PES, system and elementary streams
// - Source uses shared bus, per-stream strobes
// - Two independent parsers, audio and video; the video parser takes its stamp select from audio_stream_cfg
// - Each parser runs on its own strobe; single-strobe modes feed the audio parser from the video strobe
// - Keep only packets matching programmed stream ID
// - Queue decode or presentation stamps by select
// - On picture decode present stamp, raise flag
// - Enable bits on; cleared means elementary input
// - Two mode bits select four parse modes
// - Automatic mode detects and reports mode bit
// - Software avoids automatic mode for packetized PES; the bench runs automatic mode on PES packets
// - Single-strobe modes use video strobe only
// - PES mode uses both strobes as twins
// - Automatic mode strobes follow detected mode
// - Single strobe input split internally by ID
// - Source separates packets when using both strobes
package psp_pkg;
	// Clock and burst rate
	localparam int CLK_HZ = 20_000_000;
	localparam int BURST_MBPS = 100;
	// Least cycles between two bytes at the burst rate
	localparam int BYTE_GAP_RAW = (CLK_HZ / 1_000_000) * 8 / BURST_MBPS;
	localparam int BYTE_GAP_CYC = (BYTE_GAP_RAW < 1) ? 1 : BYTE_GAP_RAW;
	// Register byte offsets
	localparam logic [7:0] OFS_AUD_CFG = 8'h00;
	localparam logic [7:0] OFS_VID_CFG = 8'h04;
	localparam logic [7:0] OFS_AUD_SEL = 8'h08;
	localparam logic [7:0] OFS_DET = 8'h0C;
	localparam logic [7:0] OFS_INT_ST = 8'h10;
	localparam logic [7:0] OFS_INT_MSK = 8'h14;
	localparam logic [7:0] OFS_AUD_TS = 8'h18;
	localparam logic [7:0] OFS_VID_TS = 8'h1C;
	// Field positions
	localparam int CFG_ID_LSB = 8;
	localparam int CFG_SS_BIT = 0;
	localparam int CFG_SDT_BIT = 0;
	localparam int CFG_MODE_LSB = 6;
	localparam int DET_BIT = 1;
	localparam int DET_ATS32_BIT = 8;
	localparam int DET_VTS32_BIT = 9;
	// Interrupt status bits
	localparam int IRQ_ATS = 0;
	localparam int IRQ_VTS = 1;
	localparam int IRQ_AOVF = 2;
	localparam int IRQ_VOVF = 3;
	localparam int IRQ_W = 4;
	// Reset values
	localparam logic [31:0] RST_CFG = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] RST_MSK = 4'h0;
	// Stream syntax bytes
	localparam logic [7:0] SC_LAST = 8'h01;
	localparam logic [7:0] SID_LEN_MIN = 8'hBB;
	localparam logic [7:0] STUFF = 8'hFF;
	// Stamp queue depth, as log2
	localparam int TS_AW = 2;
	// AXI answers
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// Parse modes in field order
	typedef enum logic [1:0] {MODE_AUTO, MODE_SYS1, MODE_PES, MODE_PROG} psp_mode_t;
endpackage
